// ### rtl/abx_exec.v
// execute stage for accumulator, bit and watchdog-restart instructions
// assumes one instruction per mclk cycle, given with a valid strobe; the
// file memory is external with combinational read data
//
// How it works
// - add literal adds immediate to accumulator, sets c, dc, z
// - add with file adds file byte to accumulator, sets c, dc, z
// - destination bit 0 writes accumulator, 1 writes file register
// - and literal ands immediate into accumulator, sets only z
// - and with file ands, routes by destination, sets only z
// - bit clear zeroes chosen bit of file, flags untouched
// - bit set raises chosen bit of file, flags untouched
// - skip next instruction as no-operation when tested bit is zero
// - skip next instruction as no-operation when tested bit is one
// - watchdog restart clears watchdog counter and its prescaler
// - watchdog restart sets timeout and power-down flags to one
// - self-modifying port operations read pin levels, not latches
// - writing timer zero clears its prescaler when assigned to it
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "abx_map.vh"
module abx_exec (
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // instruction in
  input wire instr_valid,
  input wire [13:0] instr,
  // file memory read side
  output wire [6:0] file_addr,
  input wire [7:0] file_rdata,
  // file memory write side
  output reg file_we,
  output reg [6:0] file_waddr,
  output reg [7:0] file_wdata,
  // port pins and timer
  input wire [7:0] port_pins,
  input wire psa_timer0,
  // watchdog and timer prescalers
  output reg wdog_clear,
  output reg wdog_presc_clear,
  output reg timer0_presc_clear,
  // core state
  output reg [7:0] accum,
  output reg [4:0] status,
  output reg skip_active,
  output reg illegal
);
  //----------------------------------------
  // pin synchroniser
  //----------------------------------------
  // two flops per pin; only the second flop feeds the operand mux
  wire [7:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      reg s1;
      reg s2;
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
        end else begin
          s1 <= port_pins[gi];
          s2 <= s1;
        end
      end
      assign pin_sync[gi] = s2;
    end
  endgenerate

  //----------------------------------------
  // decode helpers
  //----------------------------------------
  // port registers sit in one address window
  function is_port;
    input [6:0] a;
    begin
      is_port = (a >= `ABX_PORT_LO) && (a <= `ABX_PORT_HI);
    end
  endfunction

  // bit-oriented group, keyed by the top four bits
  function is_bit_op;
    input [13:0] w;
    input [3:0] code;
    begin
      is_bit_op = (w[13:10] == code);
    end
  endfunction

  // byte-oriented group and and literal, keyed by the top six bits; add literal uses the top five
  function is_byte_op;
    input [13:0] w;
    input [5:0] code;
    begin
      is_byte_op = (w[13:8] == code);
    end
  endfunction

  //----------------------------------------
  // decode
  //----------------------------------------
  localparam SK_RUN = 1'b0;
  localparam SK_DROP = 1'b1;
  reg sk_state;
  wire go;
  wire [7:0] lit;
  wire dst;
  wire op_add_lit;
  wire op_add_file;
  wire op_and_lit;
  wire op_and_file;
  wire op_bit_clr;
  wire op_bit_set;
  wire op_test_zero;
  wire op_test_one;
  wire op_wdog;
  wire known;
  // a dropped slot executes as a no-operation
  assign go = instr_valid & (sk_state == SK_RUN);
  assign lit = instr[7:0];
  assign dst = instr[7];
  assign file_addr = instr[6:0];
  assign op_add_lit = go & (instr[13:9] == `ABX_OP_ADD_LIT);
  assign op_and_lit = go & is_byte_op(instr, `ABX_OP_AND_LIT);
  assign op_add_file = go & is_byte_op(instr, `ABX_OP_ADD_FILE);
  assign op_and_file = go & is_byte_op(instr, `ABX_OP_AND_FILE);
  assign op_bit_clr = go & is_bit_op(instr, `ABX_OP_BIT_CLR);
  assign op_bit_set = go & is_bit_op(instr, `ABX_OP_BIT_SET);
  assign op_test_zero = go & is_bit_op(instr, `ABX_OP_TEST_ZERO);
  assign op_test_one = go & is_bit_op(instr, `ABX_OP_TEST_ONE);
  assign op_wdog = go & (instr == `ABX_OP_WDOG_RESTART);
  assign known = op_add_lit | op_add_file | op_and_lit | op_and_file |
    op_bit_clr | op_bit_set | op_test_zero | op_test_one | op_wdog;

  //----------------------------------------
  // operand select
  //----------------------------------------
  wire lit_op;
  wire sel_and;
  wire [7:0] fsrc;
  wire [7:0] opb;
  assign lit_op = op_add_lit | op_and_lit;
  assign sel_and = op_and_lit | op_and_file;
  // port registers read the pin levels, not the output latches
  assign fsrc = is_port(file_addr) ? pin_sync : file_rdata;
  assign opb = lit_op ? lit : fsrc;

  //----------------------------------------
  // datapath
  //----------------------------------------
  wire [7:0] res;
  wire c_o;
  wire dc_o;
  wire z_o;
  wire [7:0] set_val;
  wire [7:0] clr_val;
  wire bit_val;
  abx_alu abx_alu_i (
    .opa(accum),
    .opb(opb),
    .sel_and(sel_and),
    .res(res),
    .carry(c_o),
    .dcarry(dc_o),
    .zero(z_o)
  );
  abx_bitop abx_bitop_i (
    .din(fsrc),
    .pos(instr[9:7]),
    .set_val(set_val),
    .clr_val(clr_val),
    .bit_val(bit_val)
  );

  //----------------------------------------
  // skip sequencer
  //----------------------------------------
  reg next_sk_state;
  always @* begin
    next_sk_state = sk_state;
    case (sk_state)
      SK_RUN: begin
        if (op_test_zero && !bit_val) begin
          next_sk_state = SK_DROP;
        end else if (op_test_one && bit_val) begin
          next_sk_state = SK_DROP;
        end
      end
      SK_DROP: begin
        // the pending skip is spent on the next valid slot only
        if (instr_valid) begin
          next_sk_state = SK_RUN;
        end
      end
      default: begin
        next_sk_state = SK_RUN;
      end
    endcase
  end

  //----------------------------------------
  // accumulator and flags
  //----------------------------------------
  reg [7:0] next_accum;
  reg [4:0] next_status;
  always @* begin
    next_accum = accum;
    next_status = status;
    if (op_add_lit) begin
      next_accum = res;
      next_status[`ABX_ST_C] = c_o;
      next_status[`ABX_ST_DIG] = dc_o;
      next_status[`ABX_ST_Z] = z_o;
    end else if (op_add_file) begin
      next_status[`ABX_ST_C] = c_o;
      next_status[`ABX_ST_DIG] = dc_o;
      next_status[`ABX_ST_Z] = z_o;
      if (!dst) begin
        next_accum = res;
      end
    end else if (op_and_lit) begin
      next_accum = res;
      next_status[`ABX_ST_Z] = z_o;
    end else if (op_and_file) begin
      next_status[`ABX_ST_Z] = z_o;
      if (!dst) begin
        next_accum = res;
      end
    end else if (op_wdog) begin
      next_status[`ABX_ST_TMO] = 1'b1;
      next_status[`ABX_ST_PWR] = 1'b1;
    end
  end

  //----------------------------------------
  // file write path
  //----------------------------------------
  reg next_we;
  reg [7:0] next_wdata;
  always @* begin
    next_we = 1'b0;
    next_wdata = 8'h00;
    if (op_add_file && dst) begin
      next_we = 1'b1;
      next_wdata = res;
    end else if (op_and_file && dst) begin
      next_we = 1'b1;
      next_wdata = res;
    end else if (op_bit_clr) begin
      next_we = 1'b1;
      next_wdata = clr_val;
    end else if (op_bit_set) begin
      next_we = 1'b1;
      next_wdata = set_val;
    end
  end

  //----------------------------------------
  // prescaler pulses
  //----------------------------------------
  // a write into the timer counter restarts its prescaler when it owns it
  wire next_timer0_clr;
  assign next_timer0_clr = next_we & psa_timer0 &
    (file_addr == `ABX_TIMER0_ADDR);

  //----------------------------------------
  // core registers
  //----------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      accum <= `ABX_ACC_RST;
    end else begin
      accum <= next_accum;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status <= `ABX_ST_RST;
    end else begin
      status <= next_status;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sk_state <= SK_RUN;
      skip_active <= 1'b0;
    end else begin
      sk_state <= next_sk_state;
      skip_active <= (next_sk_state == SK_DROP);
    end
  end

  //----------------------------------------
  // file write registers
  //----------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
    end else begin
      file_we <= next_we;
      file_waddr <= file_addr;
      file_wdata <= next_wdata;
    end
  end

  //----------------------------------------
  // pulse registers
  //----------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_clear <= 1'b0;
      wdog_presc_clear <= 1'b0;
    end else begin
      wdog_clear <= op_wdog;
      wdog_presc_clear <= op_wdog;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer0_presc_clear <= 1'b0;
    end else begin
      timer0_presc_clear <= next_timer0_clr;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      illegal <= 1'b0;
    end else begin
      illegal <= go & ~known;
    end
  end
endmodule

// ### rtl/abx_map.vh
// opcode fields, status bit positions and reset values of the execute block
// assumes 14-bit instruction words and a 7-bit file address
`ifndef ABX_MAP_VH
`define ABX_MAP_VH
`define ABX_OPW 14
`define ABX_FAW 7
`define ABX_OP_ADD_FILE 6'h07
`define ABX_OP_AND_FILE 6'h05
`define ABX_OP_BIT_CLR 4'h4
`define ABX_OP_BIT_SET 4'h5
`define ABX_OP_TEST_ZERO 4'h6
`define ABX_OP_TEST_ONE 4'h7
`define ABX_OP_ADD_LIT 5'h1f
`define ABX_OP_AND_LIT 6'h39
`define ABX_OP_WDOG_RESTART 14'h0064
`define ABX_ST_C 0
`define ABX_ST_DIG 1
`define ABX_ST_Z 2
`define ABX_ST_PWR 3
`define ABX_ST_TMO 4
`define ABX_ACC_RST 8'h00
`define ABX_ST_RST 5'h18
`define ABX_TIMER0_ADDR 7'h01
`define ABX_PORT_LO 7'h05
`define ABX_PORT_HI 7'h09
`endif

// ### rtl/abx_alu.v
// adder and and-unit of the execute block
// assumes operands are stable during the execute cycle
`timescale 1ns/10ps
module abx_alu (
  // operands
  input wire [7:0] opa,
  input wire [7:0] opb,
  input wire sel_and,
  // results
  output wire [7:0] res,
  output wire carry,
  output wire dcarry,
  output wire zero
);
  wire [8:0] sum;
  wire [4:0] lo;
  assign sum = {1'b0, opa} + {1'b0, opb};
  assign lo = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
  assign res = sel_and ? (opa & opb) : sum[7:0];
  assign carry = sum[8];
  assign dcarry = lo[4];
  assign zero = (res == 8'h00);
endmodule

// ### rtl/abx_bitop.v
// bit set, clear and test on one file byte
// assumes a 3-bit position field from the opcode
`timescale 1ns/10ps
module abx_bitop (
  // operand
  input wire [7:0] din,
  input wire [2:0] pos,
  // results
  output wire [7:0] set_val,
  output wire [7:0] clr_val,
  output wire bit_val
);
  wire [7:0] mask;
  assign mask = 8'h01 << pos;
  assign set_val = din | mask;
  assign clr_val = din & ~mask;
  assign bit_val = |(din & mask);
endmodule

// ### tb/abx_exec_properties.sv
// checker: port properties of the execute block
// assumes it is bound onto abx_exec
`timescale 1ns/10ps
module abx_exec_chk (
  // watched ports
  input wire mclk,
  input wire arst_n,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  input wire file_we,
  input wire [7:0] file_wdata,
  input wire [6:0] file_waddr,
  input wire psa_timer0,
  input wire timer0_presc_clear,
  input wire wdog_clear,
  input wire wdog_presc_clear,
  input wire [7:0] accum,
  input wire [4:0] status,
  input wire skip_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire tk = instr_valid && !skip_active;
  wire np = instr[6:0] < 7'h05 || instr[6:0] > 7'h09;
  wire [7:0] msk = 8'h01 << instr[9:7];
  chk_add_sum: assert property (
    tk && instr[13:9] == 5'h1f |=> accum == $past(accum + instr[7:0])
    && status[0] == $past(accum + instr[7:0] > 9'h0ff)
    && status[1] == $past(accum[3:0] + instr[3:0] > 5'h0f))
    else $error("add literal wrong");
  chk_and_zero: assert property (
    tk && instr[13:8] == 6'h39 |=> accum == $past(accum & instr[7:0])
    && status[2] == (accum == 8'h00) && status[1:0] == $past(status[1:0]))
    else $error("and literal wrong");
  chk_bit_set: assert property (
    tk && instr[13:10] == 4'h5 && np |=> file_we
    && file_wdata == $past(file_rdata | msk) && $stable(status))
    else $error("bit set wrong");
  chk_bit_clear: assert property (
    tk && instr[13:10] == 4'h4 && np |=> file_we
    && file_wdata == $past(file_rdata & ~msk) && $stable(status))
    else $error("bit clear wrong");
  chk_skip_zero: assert property (
    tk && instr[13:10] == 4'h6 && np
    |=> skip_active == ($past(file_rdata & msk) == 8'h00))
    else $error("skip on zero wrong");
  chk_skip_one: assert property (
    tk && instr[13:10] == 4'h7 && np
    |=> skip_active == ($past(file_rdata & msk) != 8'h00))
    else $error("skip on one wrong");
  chk_skip_drop: assert property (
    instr_valid && skip_active |=> !file_we && !skip_active
    && $stable(accum)) else $error("skipped slot acted");
  chk_watchdog_restart: assert property (
    tk && instr == 14'h0064 |=> wdog_clear && wdog_presc_clear
    && status[4:3] == 2'b11) else $error("watchdog restart wrong");
  chk_file_add: assert property (
    tk && instr[13:8] == 6'h07 && np
    |=> status[0] == $past({1'b0, accum} + file_rdata > 9'h0ff)
    && file_we == $past(instr[7]) && file_waddr == $past(instr[6:0])
    && ($past(instr[7]) || accum == $past(accum + file_rdata)))
    else $error("add with file wrong");
  chk_timer_presc: assert property (
    tk && instr[13:8] == 6'h07 && instr[7] && instr[6:0] == 7'h01
    && psa_timer0 |=> timer0_presc_clear)
    else $error("timer prescaler not cleared");
endmodule
bind abx_exec abx_exec_chk abx_exec_chk_i (.*);

// ### tb/tb_top.sv
// testbench: directed instructions into the execute block
// assumes the bench plays instruction source and file memory
`timescale 1ns/10ps
module tb_top;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg instr_valid = 1'b0;
  reg [13:0] instr = 14'h0000;
  reg [7:0] file_rdata = 8'h00;
  reg [7:0] port_pins = 8'ha5;
  reg psa_timer0 = 1'b1;
  wire file_we, wdog_clear, wdog_presc_clear, timer0_presc_clear;
  wire skip_active, illegal;
  wire [6:0] file_addr, file_waddr;
  wire [7:0] file_wdata, accum;
  wire [4:0] status;
  integer n_errors = 0;
  integer checks = 0;
  integer b;
  always #50 mclk = ~mclk;
  abx_exec abx_exec_i (.mclk(mclk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr(instr), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .port_pins(port_pins),
    .psa_timer0(psa_timer0), .wdog_clear(wdog_clear),
    .wdog_presc_clear(wdog_presc_clear),
    .timer0_presc_clear(timer0_presc_clear), .accum(accum), .status(status),
    .skip_active(skip_active), .illegal(illegal));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task op(input [13:0] i, input [7:0] r);
    begin
      @(posedge mclk);
      instr <= i;
      file_rdata <= r;
      instr_valid <= 1'b1;
      #1;
    end
  endtask
  task idle;
    begin
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
    end
  endtask
  task t_lit;
    begin
      op(14'h3eff, 8'h00);
      op(14'h3e01, 8'h00);
      chk(accum, 8'hff);
      op(14'h3900, 8'h00);
      chk(status[2:0], 3'h7);
      op(14'h3ef5, 8'h00);
      chk(status[2:0], 3'h7);
      idle;
      chk(accum, 8'hf5);
    end
  endtask
  task t_file;
    begin
      op(14'h07a0, 8'h0b);
      op(14'h0520, 8'h3c);
      chk({file_we, file_wdata[6:0]}, 8'h80);
      chk(file_waddr, 8'h20);
      chk({accum[6:0], status[2]}, 8'heb);
      op(14'h0781, 8'h00);
      chk({file_we, status[2:0]}, 8'h03);
      idle;
      chk(accum, 8'h34);
      chk({timer0_presc_clear, file_wdata[6:0]}, 8'hb4);
    end
  endtask
  task t_bits;
    begin
      for (b = 0; b < 8; b = b + 1) begin
        op(14'h1420 | (b << 7), 8'h00);
        op(14'h1020 | (b << 7), 8'hff);
        chk(file_wdata, 8'h01 << b);
        idle;
        chk(file_wdata, ~(8'h01 << b));
      end
      op(14'h1485, 8'h00);
      idle;
      chk(file_wdata, 8'ha7);
    end
  endtask
  task t_skip;
    begin
      op(14'h19a0, 8'hf7);
      op(14'h3e01, 8'h00);
      chk(skip_active, 8'h01);
      op(14'h1da0, 8'h08);
      op(14'h3e01, 8'h00);
      chk(skip_active, 8'h01);
      op(14'h19a0, 8'h08);
      op(14'h1da0, 8'hf7);
      chk(skip_active, 8'h00);
      idle;
      chk({skip_active, accum[6:0]}, 8'h34);
    end
  endtask
  task t_wdog;
    begin
      op(14'h0064, 8'h00);
      op(14'h3a00, 8'h00);
      chk({wdog_clear, wdog_presc_clear, status[4:3]}, 8'h0f);
      idle;
      chk({illegal, wdog_clear, accum[5:0]}, 8'hb4);
    end
  endtask
  task end_sim;
    begin
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    chk({status, accum[2:0]}, 8'hc0);
    t_lit;
    t_file;
    t_bits;
    t_skip;
    t_wdog;
    end_sim;
  end
endmodule
